// >>> design/pisl_regs.vh
`ifndef PISL_REGS_VH
`define PISL_REGS_VH

// register addresses (5-bit management address space)
`define PISL_ADDR_BMSR      5'h01
`define PISL_ADDR_STATUS    5'h11
`define PISL_ADDR_MASK      5'h1D
`define PISL_ADDR_CTRL      5'h1E

// status bit positions
`define PISL_B_CIM          15
`define PISL_B_LINK         14
`define PISL_B_LOCK         13
`define PISL_B_PREEND       12
`define PISL_B_LLC          11
`define PISL_B_BSD          10
`define PISL_B_REC          9
`define PISL_B_LOOP         8
`define PISL_B_RSTDONE      7
`define PISL_B_JAB          6
`define PISL_B_ANDONE       5
`define PISL_B_PDF          4
`define PISL_B_PFAIL        3
`define PISL_B_RFAULT       2
`define PISL_B_PAGE         1

// control register fields
`define PISL_C_COMPAT       0
`define PISL_C_SPD100       1
`define PISL_C_ANEN         2

// reset values and valid status-bit mask
`define PISL_STATUS_RST     16'h0000
`define PISL_MASK_RST       16'h0000
`define PISL_CTRL_RST       16'h0000
`define PISL_STATUS_VALID   16'hFFFE

// jabber limit
`define PISL_JAB_TIME_MS    105
`define PISL_CLK_HZ         25000000
// divide first: the plain product would overflow 32-bit integer arithmetic
`define PISL_JAB_CYCLES     (`PISL_JAB_TIME_MS * (`PISL_CLK_HZ / 1000))

`endif

// >>> design/pisl_status_latch.v
`timescale 1ns/1ps
`include "pisl_regs.vh"

module pisl_status_latch #(
	parameter JAB_CYCLES = `PISL_JAB_CYCLES
) (
	input  wire        CLOCK,
	input  wire        NRST,
	input  wire [4:0]  ADDR,
	input  wire [15:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [15:0] RDATA,
	input  wire        CIM_UNSTABLE,
	input  wire        LINK_UP,
	input  wire        DESCR_LOCKED,
	input  wire        RX_IDLE_PAIR,
	input  wire        RX_ESD_SEEN,
	input  wire        LINK_LOSS_MSB,
	input  wire        BAD_START_MSB,
	input  wire        RX_ERR_MSB,
	input  wire        LOOP_ELBUF_FAULT,
	input  wire        CAL_DONE,
	input  wire        TX_ACTIVE,
	input  wire        AN_COMPLETE,
	input  wire        AN_PDET_FAULT,
	input  wire        AN_PAR_FAIL,
	input  wire        LP_REMOTE_FAULT,
	input  wire        FEF_DETECT,
	input  wire        AN_PAGE_RX,
	output reg         TX_JAB_CUT,
	output reg         LOOP_FRAME_KILL,
	output reg         JABBER_LIVE,
	output reg         IRQ_N
);

	localparam [31:0] JAB_LIMIT = JAB_CYCLES;

	reg  [15:0] status_r;
	reg  [15:0] status_nxt;
	reg  [15:0] mask_r;
	reg  [2:0]  ctrl_r;
	reg         link_d_r;
	reg         lock_d_r;
	reg         llc_d_r;
	reg         bsd_d_r;
	reg         rec_d_r;
	reg         cal_d_r;
	reg         an_d_r;
	reg         pdf_d_r;
	reg         pfail_d_r;
	reg         lprf_d_r;
	reg         fef_d_r;
	reg         in_frame_r;
	reg         idle_pre_r;
	reg  [31:0] jab_cnt_r;
	reg         jab_hold_r;
	reg  [15:0] ev;
	reg  [15:0] eff_mask;

	wire compat   = ctrl_r[`PISL_C_COMPAT];
	wire spd100   = ctrl_r[`PISL_C_SPD100];
	wire an_en    = ctrl_r[`PISL_C_ANEN];
	wire rd_stat  = RD && (ADDR == `PISL_ADDR_STATUS);
	wire rd_bmsr  = RD && (ADDR == `PISL_ADDR_BMSR);
	// jabber trips on the cycle the count reaches one below the limit, only at 10 Mb/s
	// the hold flag stops the count parked at one below the limit from tripping every cycle
	wire jab_trip = !spd100 && TX_ACTIVE && !jab_hold_r &&
	                (jab_cnt_r == JAB_LIMIT - 32'h1);

	// event pulses; edge detectors keep one long level from re-setting after a read, except on CIM, LOOP and PAGE, which take their input level directly
	always @* begin
		ev = 16'h0000;
		ev[`PISL_B_CIM]     = CIM_UNSTABLE;
		ev[`PISL_B_LINK]    = LINK_UP ^ link_d_r;
		ev[`PISL_B_LOCK]    = DESCR_LOCKED ^ lock_d_r;
		ev[`PISL_B_PREEND]  = spd100 && in_frame_r && idle_pre_r && RX_IDLE_PAIR;
		ev[`PISL_B_LLC]     = LINK_LOSS_MSB && !llc_d_r;
		ev[`PISL_B_BSD]     = BAD_START_MSB && !bsd_d_r;
		ev[`PISL_B_REC]     = RX_ERR_MSB && !rec_d_r;
		ev[`PISL_B_LOOP]    = LOOP_ELBUF_FAULT;
		ev[`PISL_B_RSTDONE] = CAL_DONE && !cal_d_r;
		ev[`PISL_B_JAB]     = jab_trip;
		ev[`PISL_B_ANDONE]  = AN_COMPLETE && !an_d_r;
		ev[`PISL_B_PDF]     = AN_PDET_FAULT && !pdf_d_r;
		ev[`PISL_B_PFAIL]   = AN_PAR_FAIL && !pfail_d_r;
		ev[`PISL_B_RFAULT]  = an_en ? (LP_REMOTE_FAULT && !lprf_d_r)
		                            : (spd100 && FEF_DETECT && !fef_d_r);
		ev[`PISL_B_PAGE]    = AN_PAGE_RX;
	end

	// read clears, but an event in the same cycle survives
	always @* begin
		status_nxt = status_r;
		if (rd_stat)
			status_nxt = `PISL_STATUS_RST;
		if (rd_bmsr)
			status_nxt[`PISL_B_JAB] = 1'b0;
		status_nxt = (status_nxt | ev) & `PISL_STATUS_VALID;
	end

	// compatibility mode ignores the mask and passes no interrupt at all
	always @* begin
		eff_mask = compat ? 16'h0000 : mask_r;
	end

	always @(posedge CLOCK) begin
		if (!NRST) begin
			status_r        <= `PISL_STATUS_RST;
			mask_r          <= `PISL_MASK_RST;
			ctrl_r          <= 3'h0;
			link_d_r        <= 1'b0;
			lock_d_r        <= 1'b0;
			llc_d_r         <= 1'b0;
			bsd_d_r         <= 1'b0;
			rec_d_r         <= 1'b0;
			cal_d_r         <= 1'b0;
			an_d_r          <= 1'b0;
			pdf_d_r         <= 1'b0;
			pfail_d_r       <= 1'b0;
			lprf_d_r        <= 1'b0;
			fef_d_r         <= 1'b0;
			in_frame_r      <= 1'b0;
			idle_pre_r      <= 1'b0;
			jab_cnt_r       <= 32'h0;
			jab_hold_r      <= 1'b0;
			RDATA           <= 16'h0000;
			TX_JAB_CUT      <= 1'b0;
			LOOP_FRAME_KILL <= 1'b0;
			JABBER_LIVE     <= 1'b0;
			IRQ_N           <= 1'b1;
		end else begin
			status_r  <= status_nxt;
			link_d_r  <= LINK_UP;
			lock_d_r  <= DESCR_LOCKED;
			llc_d_r   <= LINK_LOSS_MSB;
			bsd_d_r   <= BAD_START_MSB;
			rec_d_r   <= RX_ERR_MSB;
			cal_d_r   <= CAL_DONE;
			an_d_r    <= AN_COMPLETE;
			pdf_d_r   <= AN_PDET_FAULT;
			pfail_d_r <= AN_PAR_FAIL;
			lprf_d_r  <= LP_REMOTE_FAULT;
			fef_d_r   <= FEF_DETECT;

			// at 100 Mb/s a frame opens on the first non-idle and closes at the end delimiter or a premature end
			if (RX_ESD_SEEN || !spd100) begin
				in_frame_r <= 1'b0;
				idle_pre_r <= 1'b0;
			end else if (!in_frame_r && !RX_IDLE_PAIR) begin
				in_frame_r <= 1'b1;
			end else if (in_frame_r) begin
				idle_pre_r <= RX_IDLE_PAIR;
				if (ev[`PISL_B_PREEND])
					in_frame_r <= 1'b0;
			end

			// transmit cut holds until the transmitter goes quiet or 100 Mb/s is selected
			if (!TX_ACTIVE || spd100) begin
				jab_cnt_r  <= 32'h0;
				jab_hold_r <= 1'b0;
			end else if (jab_trip) begin
				jab_hold_r <= 1'b1;
			end else if (!jab_hold_r) begin
				jab_cnt_r <= jab_cnt_r + 32'h1;
			end
			TX_JAB_CUT      <= jab_trip || (jab_hold_r && TX_ACTIVE && !spd100);
			LOOP_FRAME_KILL <= LOOP_ELBUF_FAULT;
			JABBER_LIVE     <= status_nxt[`PISL_B_JAB];

			if (WR && ADDR == `PISL_ADDR_MASK && !compat)
				mask_r <= WDATA & `PISL_STATUS_VALID;
			if (WR && ADDR == `PISL_ADDR_CTRL)
				ctrl_r <= WDATA[2:0];

			RDATA <= 16'h0000;
			if (RD) begin
				case (ADDR)
				`PISL_ADDR_STATUS: RDATA <= status_r;
				`PISL_ADDR_MASK:   RDATA <= mask_r;
				`PISL_ADDR_CTRL:   RDATA <= {13'h0, ctrl_r};
				default:           RDATA <= 16'h0000;
				endcase
			end

			IRQ_N <= ~|(status_nxt & eff_mask);
		end
	end

endmodule // pisl_status_latch

// >>> verif/pisl_mgmt_model.sv
`timescale 1ns/1ps
module pisl_mgmt_model (
	input  wire        CLOCK,
	output reg  [4:0]  ADDR = 5'h00,
	output reg  [15:0] WDATA = 16'h0000,
	output reg         WR = 1'b0,
	output reg         RD = 1'b0
);
	reg [15:0] q[$];
	// reads queue their expected data; the idle cycle keeps strobes from merging
	task acc(input w, input [4:0] a, input [15:0] d);
		begin
			{ADDR, WDATA, WR, RD} <= {a, d, w, !w};
			if (!w)
				q.push_back(d);
			@(posedge CLOCK);
			{WR, RD} <= 2'b00;
			@(posedge CLOCK);
		end
	endtask
endmodule // pisl_mgmt_model

// >>> verif/pisl_status_latch_chk.sv
`timescale 1ns/1ps
module pisl_status_latch_chk (
	input wire        CLOCK, NRST, RD, CIM_UNSTABLE, TX_ACTIVE, TX_JAB_CUT,
	input wire        LOOP_ELBUF_FAULT, LOOP_FRAME_KILL, JABBER_LIVE,
	input wire [4:0]  ADDR,
	input wire [15:0] RDATA
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	AST_IDLE: assert property (!RD |=> RDATA == 16'h0000) else $error("stray");
	AST_BIT0: assert property (RDATA[0] == 1'b0) else $error("bit0");
	AST_CIM: assert property (CIM_UNSTABLE ##1 (RD && ADDR == 5'h11) |=> RDATA[15])
		else $error("cim");
	AST_KILL: assert property (LOOP_ELBUF_FAULT |=> LOOP_FRAME_KILL) else $error("kill");
	AST_CUT: assert property (!TX_ACTIVE |=> !TX_JAB_CUT) else $error("cut");
	AST_HOLD: assert property (JABBER_LIVE && !RD |=> JABBER_LIVE) else $error("hold");
	AST_CLR: assert property (RD && !TX_ACTIVE && (ADDR == 5'h11 || ADDR == 5'h01)
		|=> !JABBER_LIVE) else $error("clear");
	AST_JBIT: assert property (RD && ADDR == 5'h11 |=> RDATA[6] == $past(JABBER_LIVE))
		else $error("jbit");
endmodule // pisl_status_latch_chk

// >>> verif/tb_pisl_status_latch.sv
`timescale 1ns/1ps
module tb_pisl_status_latch;
	reg         clk = 1'b0, nrst = 1'b0, tx = 1'b0, idle = 1'b1, rd_d = 1'b0;
	reg  [15:0] ev = 16'h0080;
	wire [4:0]  addr;
	wire [15:0] wdata, rdata;
	wire        wr, rd, irq_n;
	integer     bad_count = 0, checked = 0, cyc = 0, i;
	always #20 clk = ~clk;
	pisl_mgmt_model m (.CLOCK(clk), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd));
	pisl_status_latch #(.JAB_CYCLES(20)) dut (.CLOCK(clk), .NRST(nrst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CIM_UNSTABLE(ev[15]),
		.LINK_UP(ev[14]), .DESCR_LOCKED(ev[13]), .RX_IDLE_PAIR(idle), .RX_ESD_SEEN(1'b0),
		.LINK_LOSS_MSB(ev[11]), .BAD_START_MSB(ev[10]), .RX_ERR_MSB(ev[9]),
		.LOOP_ELBUF_FAULT(ev[8]), .CAL_DONE(ev[7]), .TX_ACTIVE(tx), .AN_COMPLETE(ev[5]),
		.AN_PDET_FAULT(ev[4]), .AN_PAR_FAIL(ev[3]), .LP_REMOTE_FAULT(ev[2]),
		.FEF_DETECT(ev[0]), .AN_PAGE_RX(ev[1]), .TX_JAB_CUT(), .LOOP_FRAME_KILL(),
		.JABBER_LIVE(), .IRQ_N(irq_n));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checked = checked + 1;
			bad_count = bad_count + (got !== exp);
			if (got !== exp)
				$display("CHECK FAILED %0t %h %h", $time, got, exp);
		end
	endtask
	// link and lock are levels: leave them changed, a second change would set again
	task pulse(input [15:0] b);
		begin
			ev <= ev ^ b;
			@(posedge clk);
			if (b[14:13] == 2'b00)
				ev <= ev ^ b;
		end
	endtask
	always @(posedge clk) begin
		rd_d <= rd;
		cyc = cyc + 1;
		if (rd_d)
			chk(rdata, m.q.pop_front());
		if (cyc == 3000) begin
			bad_count = bad_count + 1;
			tally_and_finish;
		end
	end
	initial begin
		i = $urandom(10);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		m.acc(1'b0, 5'h11, 16'h0080);
		m.acc(1'b0, 5'h05, 16'h0000);
		m.acc(1'b1, 5'h1E, 16'h0004);
		for (i = 1; i < 16; i = i + 1)
			if (i != 6 && i != 7 && i != 12) begin
				pulse(16'h0001 << i);
				m.acc(1'b0, 5'h11, 16'h0001 << i);
			end
		m.acc(1'b1, 5'h1E, 16'h0002);
		pulse(16'h0001);
		m.acc(1'b0, 5'h11, 16'h0004);
		idle <= 1'b0;
		repeat (3) @(posedge clk);
		idle <= 1'b1;
		repeat (3) @(posedge clk);
		m.acc(1'b0, 5'h11, 16'h1000);
		$display("event test done");
		for (i = 0; i < 3; i = i + 1) begin
			m.acc(1'b1, 5'h1E, (i == 0) ? 16'h0002 : 16'h0000);
			tx <= 1'b1;
			repeat (25) @(posedge clk);
			tx <= 1'b0;
			if (i == 1)
				m.acc(1'b0, 5'h01, 16'h0000);
			m.acc(1'b0, 5'h11, (i == 2) ? 16'h0040 : 16'h0000);
		end
		$display("jabber test done");
		m.acc(1'b1, 5'h1D, 16'($urandom) | 16'h8000);
		pulse(16'h8000);
		@(posedge clk);
		chk({15'h0000, irq_n}, 16'h0000);
		m.acc(1'b0, 5'h11, 16'h8000);
		chk({15'h0000, irq_n}, 16'h0001);
		m.acc(1'b1, 5'h1E, 16'h0001);
		pulse(16'h8000);
		@(posedge clk);
		chk({15'h0000, irq_n}, 16'h0001);
		$display("interrupt test done");
		tally_and_finish;
	end
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
endmodule // tb_pisl_status_latch
bind pisl_status_latch pisl_status_latch_chk chk (.*);
